// file: rtl/pti_defines.svh
// Constants for the two-wire target port: address, byte framing, widths.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PTI_DEFINES_SVH
`define PTI_DEFINES_SVH
`define PTI_DEV_ADDR 7'h34
`define PTI_BIT_LAST 4'h7
`define PTI_BIT_ZERO 4'h0
`define PTI_BUF_DEPTH 2
`define PTI_PTR_ZERO 1'h0
`define PTI_CNT_ZERO 2'h0
`define PTI_CNT_FULL 2'h2
`define PTI_BYTE_ZERO 8'h00
`endif

// file: rtl/pti_pkg.sv
// Types of the two-wire target port: session phase enumeration.
// Assumes pti_defines.svh sits beside it.
`include "pti_defines.svh"
package pti_pkg;
  typedef enum logic [2:0] {
    PTI_IDLE,
    PTI_ADDR,
    PTI_ADDR_ACK,
    PTI_RX,
    PTI_RX_ACK,
    PTI_TX,
    PTI_TX_ACK,
    PTI_IGNORE
  } pti_phase_t;
endpackage

// file: rtl/pti_target.sv
// Two-wire serial target: framing, address match, index and data writes
// through a two-entry buffer, direct reads. Assumes clk_sys_i well above bus clock.
// What this block does, and what it expects of the master
// [RQ1] Data line only changes while the serial clock is low.
// [RQ2] Data falling while clock high opens a session (START).
// [RQ3] Data rising while clock high closes the session (STOP).
// [RQ4] Only the master makes START and STOP; target never does.
// [RQ5] Bus busy from START to STOP, idle afterwards.
// [RQ6] Repeated START restarts address reception like a first START.
// [RQ7] Bytes are eight bits, most significant bit first.
// [RQ8] No limit on bytes per transfer.
// [RQ9] Receiver pulls data low during the ninth clock to acknowledge.
// [RQ10] Transmitter releases data during the acknowledge clock.
// [RQ11] Addressed target acknowledges every byte it receives until the write buffer is full.
// [RQ12] First byte is seven-bit address plus direction, 1 means read.
// [RQ13] Target answers only address 34 hex.
// [RQ14] Second written byte is the register index.
// [RQ15] Third written byte is stored to the indexed register.
// [RQ16] Master writes the index before starting a read.
// [RQ17] Target drives lines only low, open drain.
// [RQ18] After repeated START with read bit, target returns indexed byte.
// [RQ19] Unmatched address: keep data released until next START.
// [RQ20] Master ends read with not-acknowledge then STOP.
`timescale 1ns/100ps
`include "pti_defines.svh"
`default_nettype none
module pti_target
  import pti_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Register write stream (through buffer)
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [7:0] wr_index_o,
  output logic [7:0] wr_data_o,
  // Register read port
  output logic [7:0] rd_index_o,
  input wire logic [7:0] rd_data_i,
  // Status
  output logic busy_o
);

  // Whole state of the block
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    pti_phase_t phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic rd;
    logic have_idx;
    logic [7:0] idx;
    logic drive_low;
    logic busy;
    logic [7:0] buf_idx0;
    logic [7:0] buf_dat0;
    logic [7:0] buf_idx1;
    logic [7:0] buf_dat1;
    logic rptr;
    logic wptr;
    logic [1:0] cnt;
  } pti_state_t;

  pti_state_t st;
  pti_state_t next_st;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic push;
  logic pop;
  logic buf_full;

  // Edges seen only on the second synchroniser stage
  assign scl_rise = st.scl_s[1] && !st.scl_d;
  assign scl_fall = !st.scl_s[1] && st.scl_d;
  assign start_c = st.scl_s[1] && st.scl_d && st.sda_d && !st.sda_s[1]; // RQ2
  assign stop_c = st.scl_s[1] && st.scl_d && !st.sda_d && st.sda_s[1]; // RQ3
  assign buf_full = (st.cnt == `PTI_CNT_FULL);
  assign pop = (st.cnt != `PTI_CNT_ZERO) && wr_ready_i;

  // Next-state logic
  always_comb begin
    next_st = st;
    push = 1'b0;
    next_st.scl_s = {st.scl_s[0], scl_i};
    next_st.sda_s = {st.sda_s[0], sda_i};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];
    if (start_c) begin
      // Repeated START behaves exactly like the first
      next_st.phase = PTI_ADDR; // RQ6
      next_st.bitn = `PTI_BIT_ZERO;
      next_st.busy = 1'b1; // RQ5
      next_st.drive_low = 1'b0;
      next_st.have_idx = 1'b0;
    end else if (stop_c) begin
      next_st.phase = PTI_IDLE; // RQ5
      next_st.busy = 1'b0;
      next_st.drive_low = 1'b0; // RQ20
    end else if (scl_rise) begin
      // Sample data while clock high, MSB first
      case (st.phase)
        PTI_ADDR, PTI_RX: begin
          next_st.shift = {st.shift[6:0], st.sda_s[1]}; // RQ7
          next_st.bitn = st.bitn + 4'h1;
        end
        PTI_TX_ACK: begin
          // Master not-acknowledge ends our sending
          if (st.sda_s[1]) begin
            next_st.phase = PTI_IGNORE; // RQ20
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin // RQ1
      // Change drive only while clock low
      case (st.phase)
        PTI_ADDR: begin
          if (st.bitn > `PTI_BIT_LAST) begin
            if (st.shift[7:1] == `PTI_DEV_ADDR) begin // RQ13
              next_st.phase = PTI_ADDR_ACK;
              next_st.rd = st.shift[0]; // RQ12
              next_st.drive_low = 1'b1; // RQ9
            end else begin
              next_st.phase = PTI_IGNORE; // RQ19
            end
          end
        end
        PTI_ADDR_ACK, PTI_TX_ACK: begin
          next_st.bitn = `PTI_BIT_ZERO;
          if (st.rd) begin
            next_st.phase = PTI_TX;
            next_st.shift = rd_data_i; // RQ18
            next_st.drive_low = !rd_data_i[7];
            next_st.idx = st.idx + 8'h01;
            next_st.bitn = 4'h1;
          end else begin
            next_st.phase = PTI_RX;
            next_st.drive_low = 1'b0; // RQ10
          end
        end
        PTI_RX: begin
          if (st.bitn > `PTI_BIT_LAST) begin
            if (!st.have_idx) begin
              next_st.idx = st.shift; // RQ14
              next_st.have_idx = 1'b1;
              next_st.phase = PTI_RX_ACK;
              next_st.drive_low = 1'b1; // RQ11
            end else if (!buf_full) begin
              push = 1'b1; // RQ15
              next_st.idx = st.idx + 8'h01; // RQ8
              next_st.phase = PTI_RX_ACK;
              next_st.drive_low = 1'b1; // RQ11
            end else begin
              // Buffer full: refuse the byte by not acknowledging
              next_st.phase = PTI_IGNORE;
            end
          end
        end
        PTI_RX_ACK: begin
          next_st.phase = PTI_RX;
          next_st.bitn = `PTI_BIT_ZERO;
          next_st.drive_low = 1'b0;
        end
        PTI_TX: begin
          if (st.bitn > `PTI_BIT_LAST) begin
            next_st.phase = PTI_TX_ACK;
            next_st.drive_low = 1'b0; // RQ10
          end else begin
            next_st.drive_low = !st.shift[3'd7 - st.bitn[2:0]]; // RQ7
            next_st.bitn = st.bitn + 4'h1;
          end
        end
        default: begin
          next_st.drive_low = 1'b0;
        end
      endcase
    end
    // Two-entry write buffer
    if (push) begin
      if (st.wptr) begin
        next_st.buf_idx1 = st.idx;
        next_st.buf_dat1 = st.shift;
      end else begin
        next_st.buf_idx0 = st.idx;
        next_st.buf_dat0 = st.shift;
      end
      next_st.wptr = !st.wptr;
    end
    if (pop) begin
      next_st.rptr = !st.rptr;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.scl_s <= 2'h3;
      st.sda_s <= 2'h3;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
      st.phase <= PTI_IDLE;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // Outputs; clock line never driven, data only pulled low
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_oe_o <= 1'b0;
      wr_valid_o <= 1'b0;
      wr_index_o <= `PTI_BYTE_ZERO;
      wr_data_o <= `PTI_BYTE_ZERO;
      rd_index_o <= `PTI_BYTE_ZERO;
      busy_o <= 1'b0;
    end else if (clk_en_i) begin
      sda_oe_o <= next_st.drive_low; // RQ17
      wr_valid_o <= (next_st.cnt != `PTI_CNT_ZERO);
      wr_index_o <= next_st.rptr ? next_st.buf_idx1 : next_st.buf_idx0;
      wr_data_o <= next_st.rptr ? next_st.buf_dat1 : next_st.buf_dat0;
      rd_index_o <= next_st.idx;
      busy_o <= next_st.busy;
    end
  end

  // Constant low levels for open-drain drivers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end
  end

  // Drive changes only while bus clock low
  data_stable_a: assert property ( // RQ1
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $changed(sda_oe_o) |-> !st.scl_d) else $error("sda changed, scl high");
  start_busy_a: assert property ( // RQ2
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && start_c |=> ##1 busy_o) else $error("busy missing");
  stop_idle_a: assert property ( // RQ3
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && stop_c && !start_c |=> ##1 !busy_o)
    else $error("busy stuck");
  restart_addr_a: assert property ( // RQ6
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && start_c |=> st.phase == PTI_ADDR) else $error("no restart");
  open_drain_a: assert property ( // RQ17
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !sda_o && !scl_oe_o) else $error("high drive");
  ignore_quiet_a: assert property ( // RQ19
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st.phase == PTI_IGNORE |-> !st.drive_low) else $error("drive ignored");
  sequence addr_ack_s;
    st.phase == PTI_ADDR_ACK;
  endsequence
  addr_ack_a: assert property ( // RQ9
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    addr_ack_s |-> st.drive_low) else $error("no address ack");
  rx_ack_a: assert property ( // RQ11
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st.phase == PTI_RX_ACK |-> st.drive_low) else $error("no data ack");
  tx_release_a: assert property ( // RQ10
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st.phase == PTI_TX_ACK |-> !st.drive_low) else $error("held in ack");
  match_addr_a: assert property ( // RQ13
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(st.phase == PTI_ADDR_ACK) |->
    $past(st.shift[7:1]) == `PTI_DEV_ADDR) else $error("wrong address acked");

  // Session framing; a quiet line while idle
  stop_phase_a: assert property ( // RQ5
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && stop_c && !start_c |=> st.phase == PTI_IDLE)
    else $error("no idle after stop");
  idle_quiet_a: assert property ( // RQ5
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st.phase == PTI_IDLE |-> !st.drive_low) else $error("drive while idle");
  oe_follow_a: assert property ( // RQ17
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i |=> sda_oe_o == st.drive_low) else $error("pin enable lags");

  // Byte-end events; each opens a check one edge later
  sequence addr_miss_s;
    clk_en_i && scl_fall && st.phase == PTI_ADDR &&
    st.bitn > `PTI_BIT_LAST && st.shift[7:1] != `PTI_DEV_ADDR;
  endsequence
  sequence rx_byte_s;
    clk_en_i && scl_fall && st.phase == PTI_RX &&
    st.bitn > `PTI_BIT_LAST && (!st.have_idx || !buf_full);
  endsequence
  sequence tx_byte_s;
    clk_en_i && scl_fall && st.phase == PTI_TX && st.bitn > `PTI_BIT_LAST;
  endsequence
  sequence tx_load_s;
    clk_en_i && scl_fall && st.phase == PTI_ADDR_ACK && st.rd;
  endsequence
  sequence host_nack_s;
    clk_en_i && scl_rise && st.phase == PTI_TX_ACK && st.sda_s[1];
  endsequence
  addr_miss_a: assert property ( // RQ19
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    addr_miss_s |=> st.phase == PTI_IGNORE && !st.drive_low)
    else $error("foreign address taken");
  rx_byte_a: assert property ( // RQ11
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rx_byte_s |=> st.phase == PTI_RX_ACK && st.drive_low)
    else $error("byte not acknowledged");
  tx_byte_a: assert property ( // RQ10
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_byte_s |=> st.phase == PTI_TX_ACK && !st.drive_low)
    else $error("line held after byte");
  tx_load_a: assert property ( // RQ18
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_load_s |=> st.phase == PTI_TX && st.drive_low == !$past(rd_data_i[7]))
    else $error("wrong first read bit");
  host_nack_a: assert property ( // RQ20
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    host_nack_s |=> st.phase == PTI_IGNORE) else $error("sent past nack");

  // Write buffer: bounded, and the head word holds until taken
  buf_cap_a: assert property ( // RQ15
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st.cnt <= `PTI_CNT_FULL) else $error("buffer overfilled");
  valid_hold_a: assert property ( // RQ15
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && wr_valid_o && !wr_ready_i |=> wr_valid_o &&
    $stable(wr_data_o) && $stable(wr_index_o)) else $error("head word lost");

endmodule
`default_nettype wire

// file: tb/pti_master.sv
// Bus master model driving both wires by pull-low enables.
// Assumes the bench adds pull-ups and runs clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module pti_master (
  // Clock, wire, pace
  input wire logic clk_sys_i,
  input wire logic sda_i,
  input wire logic slow_i,
  // Pull-low enables
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'h0;
    sda_low_o = 1'h0;
  end
  // Quarter bit; slow mode doubles it
  task automatic qw();
    repeat (slow_i ? 4 : 2) @(posedge clk_sys_i);
  endtask
  // Start, also repeated start from clock low
  task automatic start();
    sda_low_o <= 1'h0;
    qw();
    scl_low_o <= 1'h0;
    qw();
    sda_low_o <= 1'h1;
    qw();
    scl_low_o <= 1'h1;
    qw();
  endtask
  task automatic stop();
    sda_low_o <= 1'h1;
    qw();
    scl_low_o <= 1'h0;
    qw();
    sda_low_o <= 1'h0;
    qw();
  endtask
  // Data set while clock low; sampled off-edge to dodge races
  task automatic bit_x(input logic b, output logic r);
    sda_low_o <= !b;
    qw();
    scl_low_o <= 1'h0;
    qw();
    @(negedge clk_sys_i) r = sda_i;
    qw();
    scl_low_o <= 1'h1;
    qw();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'h1, r);
      d[i] = r;
    end
    bit_x(!ack, r);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench for the two-wire target: random bursts, refusals.
// Assumes rtl files and the master model are compiled first.
`timescale 1ns/100ps
`include "pti_defines.svh"
`default_nettype none
module tb_top;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic wr_ready_i = 1'h0;
  logic stall = 1'h0;
  logic slow = 1'h0;
  logic bad = 1'h0;
  logic scl_low, sda_low, scl_o, scl_oe, sda_o, sda_oe, wr_valid, busy;
  logic [7:0] wr_index, wr_data, rd_index;
  logic [7:0] regs [256];
  logic [7:0] expv [256];
  logic [31:0] seed = 32'h00011d84;
  int n_mismatch = 0;
  int compares = 0;
  // Open-drain wires with pull-ups
  wire logic scl = !scl_low && !(scl_oe && !scl_o);
  wire logic sda = !sda_low && !(sda_oe && !sda_o);
  wire logic [7:0] rd_data = regs[rd_index];
  always #25 clk_sys_i = !clk_sys_i;
  pti_target i_pti_target (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'h1), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready_i), .wr_index_o(wr_index), .wr_data_o(wr_data),
    .rd_index_o(rd_index), .rd_data_i(rd_data), .busy_o(busy));
  pti_master i_pti_master (.clk_sys_i(clk_sys_i), .sda_i(sda),
    .slow_i(slow), .scl_low_o(scl_low), .sda_low_o(sda_low));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] adr(input logic rw, input logic hit);
    return {hit ? `PTI_DEV_ADDR : 7'h35, rw};
  endfunction
  // Consumer with random stalls and a forced stall, so the buffer really fills
  always @(posedge clk_sys_i) begin
    seed <= xs(seed);
    wr_ready_i <= !stall && seed[3];
    if (wr_valid && wr_ready_i) regs[wr_index] <= wr_data;
    if (scl_oe || scl_o || (sda_oe && sda_o)) bad <= 1'h1;
  end
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the expected run
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_mismatch++;
    print_verdict();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    i_pti_master.put_byte(d, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic finish_xfer();
    i_pti_master.stop();
    for (int i = 0; i < 40 && busy !== 1'h0; i++) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({7'h00, busy}, 8'h00);
  endtask
  // Bytes past the room left in the buffer are refused
  task automatic wr_burst(input logic [7:0] ix, input int n, input int room);
    logic [7:0] d;
    i_pti_master.start();
    send(adr(1'h0, 1'h1), 1'h1);
    chk({7'h00, busy}, 8'h01);
    send(ix, 1'h1);
    for (int j = 0; j < n; j++) begin
      d = seed[15:8];
      if (j < room) expv[8'(ix + j)] = d;
      send(d, j < room);
    end
    finish_xfer();
  endtask
  task automatic rd_burst(input logic [7:0] ix, input int n);
    logic [7:0] d;
    i_pti_master.start();
    send(adr(1'h0, 1'h1), 1'h1);
    send(ix, 1'h1);
    i_pti_master.start();
    send(adr(1'h1, 1'h1), 1'h1);
    for (int j = 0; j < n; j++) begin
      i_pti_master.get_byte(j < n - 1, d);
      chk(d, expv[8'(ix + j)]);
    end
    finish_xfer();
  endtask
  // Main sequence
  initial begin
    logic [7:0] ix;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    for (int k = 0; k < 4; k++) begin
      ix = seed[7:0];
      slow <= k[0];
      wr_burst(ix, k + 1, 8);
      rd_burst(ix, k + 1);
    end
    $display("test bursts done");
    i_pti_master.start();
    send(adr(1'h0, 1'h0), 1'h0);
    send(8'h5a, 1'h0);
    i_pti_master.start();
    send(adr(1'h0, 1'h1), 1'h1);
    finish_xfer();
    $display("test address done");
    // Stalled consumer: buffer fills, third word refused, then drains
    stall <= 1'h1;
    wr_burst(8'hfe, 3, `PTI_BUF_DEPTH);
    stall <= 1'h0;
    rd_burst(8'hfe, 2);
    chk({7'h00, wr_valid}, 8'h00);
    chk({7'h00, bad}, 8'h00);
    $display("test buffer done");
    print_verdict();
  end
endmodule
`default_nettype wire
